// file: rtl/mhr_consts.svh
// mhr_consts.svh: offsets, bit positions and reset values of the interface bits
// assumes: included by bare name from the package only; the modules use its macros without including it
`ifndef MHR_CONSTS_SVH
`define MHR_CONSTS_SVH

// ----------------------------------------
// register offsets (byte index on the plain port)
// ----------------------------------------
`define MHR_OFF_RBUF 8'h00
`define MHR_OFF_CDEN 8'h03
`define MHR_OFF_LOOP 8'h07
`define MHR_OFF_RENEG 8'h0E
`define MHR_OFF_LINE 8'h0F
`define MHR_OFF_WAKE 8'h15
`define MHR_OFF_RIOVR 8'h1A
`define MHR_OFF_RBST 8'h1E
`define MHR_OFF_IRQST 8'h20
`define MHR_OFF_IRQMSK 8'h21

// ----------------------------------------
// bit positions
// ----------------------------------------
`define MHR_BIT_RBF 0
`define MHR_BIT_RBIE 2
`define MHR_BIT_RBIA 6
`define MHR_BIT_RLREQ 6
`define MHR_BIT_RLEN 7
`define MHR_BIT_RWAKE 5
`define MHR_BIT_RIST 3
`define MHR_BIT_CDST 7
`define MHR_BIT_CDEN 4
`define MHR_BIT_ROEN 6
`define MHR_BIT_ROST 5
`define MHR_BIT_RNG 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define MHR_RST_RBIE 1'b0
`define MHR_RST_RLEN 1'b1
`define MHR_RST_RLREQ 1'b0
`define MHR_RST_RWAKE 1'b1
`define MHR_RST_CDEN 1'b1
`define MHR_RST_ROEN 1'b0
`define MHR_RST_ROST 1'b0
`define MHR_RST_MASK 4'h0

// ----------------------------------------
// event status layout (0x20 / 0x21)
// ----------------------------------------
`define MHR_EV_RBF 0
`define MHR_EV_RING 1
`define MHR_EV_RENEG 2
`define MHR_EV_CD 3
`define MHR_NEV 4

`endif

// file: rtl/mhr_evt.sv
// mhr_evt.sv: sticky event bits cleared by a read, mask, one level interrupt
// assumes: events are single-cycle pulses in the i_clk domain
`timescale 1ns/1ps
module mhr_evt
    import mhr_pkg::*;
#(
    parameter int N = 4
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [N-1:0] i_event,
    input wire logic i_clear,
    input wire logic i_mask_we,
    input wire logic [N-1:0] i_mask_wd,
    output logic [N-1:0] o_status,
    output logic [N-1:0] o_mask,
    output logic o_irq
);
    logic [N-1:0] st_q;
    logic [N-1:0] st_d;
    logic [N-1:0] mk_q;
    logic [N-1:0] mk_d;

    always_comb
    begin
        // a new event wins over the clearing read
        st_d = (i_clear ? '0 : st_q) | i_event;
        mk_d = i_mask_we ? i_mask_wd : mk_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= '0;
            mk_q <= `MHR_RST_MASK;
        end
        else
        begin
            st_q <= st_d;
            mk_q <= mk_d;
        end
    end

    assign o_status = st_q;
    assign o_mask = mk_q;
    assign o_irq = |(st_q & mk_q);
endmodule : mhr_evt

// file: rtl/mhr_pkg.sv
// mhr_pkg.sv: loopback state type for the receive/ring/loopback interface bits
// assumes: mhr_consts.svh on the include path
`include "mhr_consts.svh"
package mhr_pkg;
    typedef enum logic [1:0] {
        MHR_LB_IDLE = 2'b00,
        MHR_LB_REQ = 2'b01,
        MHR_LB_LOCAL = 2'b11,
        MHR_LB_REMOTE = 2'b10
    } mhr_lb_t;
endpackage : mhr_pkg

// file: rtl/mhr_ring.sv
// mhr_ring.sv: ring-detect input conditioning and sleep wake request
// assumes: ring detector in the pump delivers ring on/off cadence as a level
`timescale 1ns/1ps
module mhr_ring
    import mhr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ring_detect_input,
    input wire logic i_ring_on,
    input wire logic i_data_mode,
    input wire logic i_tone_mode,
    input wire logic i_sleeping,
    input wire logic i_ring_wake_enable,
    output logic o_ring_status,
    output logic o_wake,
    output logic o_ring_rise
);
    logic rd_q;
    logic rd_d;
    logic st_q;
    logic st_d;
    logic wk_q;
    logic wk_d;

    always_comb
    begin
        rd_d = i_ring_detect_input;
        // ring status only meaningful outside data and tone modes
        st_d = i_ring_on & ~i_data_mode & ~i_tone_mode; // RQ11
        // input idles low: a rising edge while asleep is a ring
        wk_d = i_ring_wake_enable & i_sleeping & i_ring_detect_input & ~rd_q; // RQ10
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_q <= 1'b0;
            st_q <= 1'b0;
            wk_q <= 1'b0;
        end
        else
        begin
            rd_q <= rd_d;
            st_q <= st_d;
            wk_q <= wk_d;
        end
    end

    assign o_ring_status = st_q;
    assign o_wake = wk_q;
    assign o_ring_rise = st_d & ~st_q;
endmodule : mhr_ring

// file: rtl/mhr_top.sv
// mhr_top.sv: receive buffer, loopback, ring, carrier-detect and renegotiation bits
// assumes: single 125 MHz clock; register port with one-cycle strobes, read data next cycle
// Notes on behaviour
// RQ1: received channel byte lands in an 8-bit buffer, valid while full flag set.
// RQ2: receiver write sets buffer-full flag; may raise interrupt request.
// RQ3: host read of buffer clears full flag and interrupt-active flag.
// RQ4: enable set and full flag rising raises interrupt and sets active flag.
// RQ5: enable clear (reset 0): full flag never affects interrupt or active flag; code raises the interrupt on a received byte when event mask bit 0 is set.
// RQ6: loopback request sends request, clamps data to mark, holds CTS low until loop.
// RQ7: host should set response enable before setting loopback request.
// RQ8: response enable (reset 1): remote request enters loop, clamps, resets bits, sets test mode.
// RQ9: response enable clear: remote loopback requests are ignored, no response.
// RQ10: ring wake (reset 1) wakes a sleeping device on ring; input idles low.
// RQ11: ring status follows ring on/off, valid only out of data and tone modes.
// RQ12: override enable drives ring output from override state, else detected ringing; code ignores override enable in data mode.
// RQ13: carrier status set on trained or energy with data; reset idle or training.
// RQ14: carrier pin enable (reset 1) mirrors status; clear forces pin off, data mark.
// RQ15: renegotiation-detected bit set on detection, held until host writes it clear.
// RQ16: interrupt output stays high while any enabled active flag stays set.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module mhr_top
    import mhr_pkg::*;
#(
    parameter int DW = 8
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_rx_byte_valid,
    input wire logic [DW-1:0] i_rx_byte,
    input wire logic i_rx_bit,
    output logic o_rx_bit,
    input wire logic i_ring_detect_input,
    input wire logic i_ring_on,
    input wire logic i_data_mode,
    input wire logic i_tone_mode,
    input wire logic i_sleeping,
    output logic o_wake,
    output logic o_ring_indicator_output_n,
    input wire logic i_rx_trained,
    input wire logic i_rx_energy,
    input wire logic i_rx_idle,
    input wire logic i_rx_training,
    output logic o_carrier_detect_pin_n,
    input wire logic i_cts,
    input wire logic i_dsr,
    output logic o_cts_pin_n,
    output logic o_dsr_pin_n,
    output logic o_cts_status,
    output logic o_dsr_status,
    output logic o_send_loop_request,
    input wire logic i_loop_established,
    input wire logic i_remote_loop_request,
    input wire logic i_remote_loop_end,
    output logic o_test_mode_flag,
    input wire logic i_reneg_detect,
    output logic o_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [DW-1:0] buf_q, buf_d;
    logic rbf_q, rbf_d;
    logic rbia_q, rbia_d;
    logic rbie_q, rbie_d;
    logic rlreq_q, rlreq_d;
    logic rlen_q, rlen_d;
    logic rwake_q, rwake_d;
    logic cden_q, cden_d;
    logic roen_q, roen_d;
    logic rost_q, rost_d;
    logic cd_q, cd_d;
    logic rng_q, rng_d;
    logic [7:0] rdata_q, rdata_d;
    mhr_lb_t lb_q, lb_d;

    logic ring_st;
    logic ring_rise;
    logic rbuf_rd;
    logic [`MHR_NEV-1:0] ev;
    logic [`MHR_NEV-1:0] ev_st;
    logic [`MHR_NEV-1:0] ev_mk;
    logic ev_irq;
    logic ev_clr;
    logic ev_mk_we;
    logic in_loop;
    logic clamp;

    assign rbuf_rd = i_rd && (i_addr == `MHR_OFF_RBUF);
    assign ev_clr = i_rd && (i_addr == `MHR_OFF_IRQST);
    assign ev_mk_we = i_wr && (i_addr == `MHR_OFF_IRQMSK);

    // ----------------------------------------
    // ring logic
    // ----------------------------------------
    mhr_ring u_ring (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ring_detect_input(i_ring_detect_input),
        .i_ring_on(i_ring_on),
        .i_data_mode(i_data_mode),
        .i_tone_mode(i_tone_mode),
        .i_sleeping(i_sleeping),
        .i_ring_wake_enable(rwake_q),
        .o_ring_status(ring_st),
        .o_wake(o_wake),
        .o_ring_rise(ring_rise)
    );

    // ----------------------------------------
    // receive buffer and its interrupt flags
    // ----------------------------------------
    always_comb
    begin
        buf_d = buf_q;
        rbf_d = rbf_q;
        rbia_d = rbia_q;
        if (i_rx_byte_valid)
            buf_d = i_rx_byte; // RQ1
        if (rbuf_rd)
        begin
            rbf_d = 1'b0; // RQ3
            rbia_d = 1'b0; // RQ3
        end
        // a byte arriving with the read wins, so it is not lost
        if (i_rx_byte_valid)
        begin
            rbf_d = 1'b1; // RQ2
            rbia_d = rbie_q; // RQ4 RQ5
        end
    end

    // ----------------------------------------
    // control bits written by the host
    // ----------------------------------------
    always_comb
    begin
        rbie_d = rbie_q;
        rlreq_d = rlreq_q;
        rlen_d = rlen_q;
        rwake_d = rwake_q;
        cden_d = cden_q;
        roen_d = roen_q;
        rost_d = rost_q;
        rng_d = rng_q;
        if (i_wr)
        begin
            unique case (i_addr)
                `MHR_OFF_RBST: rbie_d = i_wdata[`MHR_BIT_RBIE];
                `MHR_OFF_LOOP:
                begin
                    rlreq_d = i_wdata[`MHR_BIT_RLREQ];
                    rlen_d = i_wdata[`MHR_BIT_RLEN];
                end
                `MHR_OFF_WAKE: rwake_d = i_wdata[`MHR_BIT_RWAKE];
                `MHR_OFF_CDEN: cden_d = i_wdata[`MHR_BIT_CDEN];
                `MHR_OFF_RIOVR:
                begin
                    roen_d = i_wdata[`MHR_BIT_ROEN];
                    rost_d = i_wdata[`MHR_BIT_ROST];
                end
                `MHR_OFF_RENEG: rng_d = rng_q & i_wdata[`MHR_BIT_RNG]; // RQ15
                default: ;
            endcase
        end
        if (i_reneg_detect)
            rng_d = 1'b1; // RQ15
        // carrier status from receiver state
        if (i_rx_idle || i_rx_training)
            cd_d = 1'b0; // RQ13
        else if (i_rx_trained || i_rx_energy)
            cd_d = 1'b1; // RQ13
        else
            cd_d = cd_q;
    end

    // ----------------------------------------
    // loopback sequencing
    // ----------------------------------------
    always_comb
    begin
        lb_d = lb_q;
        unique case (lb_q)
            MHR_LB_IDLE:
                if (rlreq_q)
                    lb_d = MHR_LB_REQ; // RQ6
                else if (i_remote_loop_request && rlen_q)
                    lb_d = MHR_LB_REMOTE; // RQ8 RQ9
            MHR_LB_REQ:
                if (!rlreq_q)
                    lb_d = MHR_LB_IDLE;
                else if (i_loop_established)
                    lb_d = MHR_LB_LOCAL; // RQ6
            MHR_LB_LOCAL:
                if (!rlreq_q)
                    lb_d = MHR_LB_IDLE;
            MHR_LB_REMOTE:
                if (i_remote_loop_end)
                    lb_d = MHR_LB_IDLE;
        endcase
    end

    assign in_loop = (lb_q == MHR_LB_REMOTE);
    assign clamp = in_loop || (lb_q == MHR_LB_REQ) || !cden_q; // RQ6 RQ8 RQ14

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_comb
    begin
        rdata_d = 8'h00;
        if (i_rd)
        begin
            unique case (i_addr)
                `MHR_OFF_RBUF: rdata_d = 8'(buf_q);
                `MHR_OFF_RBST:
                begin
                    rdata_d[`MHR_BIT_RBF] = rbf_q;
                    rdata_d[`MHR_BIT_RBIE] = rbie_q;
                    rdata_d[`MHR_BIT_RBIA] = rbia_q;
                end
                `MHR_OFF_LOOP:
                begin
                    rdata_d[`MHR_BIT_RLREQ] = rlreq_q;
                    rdata_d[`MHR_BIT_RLEN] = rlen_q;
                end
                `MHR_OFF_WAKE: rdata_d[`MHR_BIT_RWAKE] = rwake_q;
                `MHR_OFF_CDEN: rdata_d[`MHR_BIT_CDEN] = cden_q;
                `MHR_OFF_RIOVR:
                begin
                    rdata_d[`MHR_BIT_ROEN] = roen_q;
                    rdata_d[`MHR_BIT_ROST] = rost_q;
                end
                `MHR_OFF_LINE:
                begin
                    rdata_d[`MHR_BIT_CDST] = cd_q & ~in_loop; // RQ8 RQ13
                    rdata_d[`MHR_BIT_RIST] = ring_st; // RQ11
                end
                `MHR_OFF_RENEG: rdata_d[`MHR_BIT_RNG] = rng_q;
                `MHR_OFF_IRQST: rdata_d[`MHR_NEV-1:0] = ev_st;
                `MHR_OFF_IRQMSK: rdata_d[`MHR_NEV-1:0] = ev_mk;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            buf_q <= '0;
            rbf_q <= 1'b0;
            rbia_q <= 1'b0;
            rbie_q <= `MHR_RST_RBIE;
            rlreq_q <= `MHR_RST_RLREQ;
            rlen_q <= `MHR_RST_RLEN;
            rwake_q <= `MHR_RST_RWAKE;
            cden_q <= `MHR_RST_CDEN;
            roen_q <= `MHR_RST_ROEN;
            rost_q <= `MHR_RST_ROST;
            cd_q <= 1'b0;
            rng_q <= 1'b0;
            rdata_q <= 8'h00;
            lb_q <= MHR_LB_IDLE;
        end
        else
        begin
            buf_q <= buf_d;
            rbf_q <= rbf_d;
            rbia_q <= rbia_d;
            rbie_q <= rbie_d;
            rlreq_q <= rlreq_d;
            rlen_q <= rlen_d;
            rwake_q <= rwake_d;
            cden_q <= cden_d;
            roen_q <= roen_d;
            rost_q <= rost_d;
            cd_q <= cd_d;
            rng_q <= rng_d;
            rdata_q <= rdata_d;
            lb_q <= lb_d;
        end
    end

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    assign ev[`MHR_EV_RBF] = i_rx_byte_valid;
    assign ev[`MHR_EV_RING] = ring_rise;
    assign ev[`MHR_EV_RENEG] = i_reneg_detect & ~rng_q;
    assign ev[`MHR_EV_CD] = cd_d & ~cd_q;

    mhr_evt #(.N(`MHR_NEV)) u_evt (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_event(ev),
        .i_clear(ev_clr),
        .i_mask_we(ev_mk_we),
        .i_mask_wd(i_wdata[`MHR_NEV-1:0]),
        .o_status(ev_st),
        .o_mask(ev_mk),
        .o_irq(ev_irq)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_irq = rbia_q | ev_irq; // RQ4 RQ16
    assign o_rdata = rdata_q;
    assign o_rx_bit = clamp ? 1'b1 : i_rx_bit; // RQ6 RQ8 RQ14
    assign o_carrier_detect_pin_n = (cden_q && !in_loop) ? ~cd_q : 1'b1; // RQ14 RQ8
    assign o_cts_status = i_cts & ~in_loop & (lb_q != MHR_LB_REQ); // RQ6 RQ8
    assign o_dsr_status = i_dsr & ~in_loop; // RQ8
    assign o_cts_pin_n = ~o_cts_status;
    assign o_dsr_pin_n = ~o_dsr_status;
    assign o_send_loop_request = (lb_q == MHR_LB_REQ); // RQ6
    assign o_test_mode_flag = in_loop; // RQ8
    assign o_ring_indicator_output_n = (roen_q && !i_data_mode) ? ~rost_q : ~ring_st; // RQ12
endmodule : mhr_top

// file: tb/mhr_checker.sv
// mhr_checker.sv: port-level assertions for mhr_top
// assumes: bound to every mhr_top instance, one clock domain
`timescale 1ns/1ps
module mhr_checker
    import mhr_pkg::*;
#(
    parameter int DW = 8
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] o_rdata,
    input wire logic i_rx_byte_valid,
    input wire logic [DW-1:0] i_rx_byte,
    input wire logic o_rx_bit,
    input wire logic i_rx_idle,
    input wire logic o_carrier_detect_pin_n,
    input wire logic o_cts_pin_n,
    input wire logic o_dsr_pin_n,
    input wire logic o_cts_status,
    input wire logic o_dsr_status,
    input wire logic o_send_loop_request,
    input wire logic i_remote_loop_request,
    input wire logic o_test_mode_flag,
    input wire logic i_reneg_detect
);
    // ----------------------------------------
    // last byte handed over by the receiver
    // ----------------------------------------
    logic [7:0] last_q;
    logic [7:0] last_d;
    always_comb last_d = i_rx_byte_valid ? 8'(i_rx_byte) : last_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
            last_q <= 8'h00;
        else
            last_q <= last_d;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_buf_read;
        (i_rd && i_addr == 8'h00 && !i_rx_byte_valid) |=> o_rdata == $past(last_q);
    endproperty
    a_buf_read: assert property (p_buf_read) else $error("buffer read wrong byte");
    property p_full_set;
        i_rx_byte_valid ##1 !i_rd ##1 (i_rd && i_addr == 8'h1E) |=> o_rdata[0];
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set");
    property p_full_clr;
        (i_rd && i_addr == 8'h00 && !i_rx_byte_valid) ##1 (!i_rx_byte_valid [*3]) ##0
            (i_rd && i_addr == 8'h1E) |=> o_rdata[0] == 1'b0 && o_rdata[6] == 1'b0;
    endproperty
    a_full_clr: assert property (p_full_clr) else $error("flags not cleared by read");
    property p_loop_req;
        o_send_loop_request |-> o_rx_bit && o_cts_pin_n && !o_cts_status;
    endproperty
    a_loop_req: assert property (p_loop_req) else $error("request state not clamped");
    property p_remote;
        o_test_mode_flag |-> o_rx_bit && o_cts_pin_n && o_dsr_pin_n && o_carrier_detect_pin_n
            && !o_cts_status && !o_dsr_status;
    endproperty
    a_remote: assert property (p_remote) else $error("remote loop outputs wrong");
    property p_tm_cause;
        $rose(o_test_mode_flag) |-> $past(i_remote_loop_request);
    endproperty
    a_tm_cause: assert property (p_tm_cause) else $error("test mode without request");
    property p_cd_idle;
        i_rx_idle [*2] |-> o_carrier_detect_pin_n;
    endproperty
    a_cd_idle: assert property (p_cd_idle) else $error("carrier pin on while idle");
    property p_reneg;
        i_reneg_detect ##1 !i_wr ##1 (i_rd && i_addr == 8'h0E) |=> o_rdata[5];
    endproperty
    a_reneg: assert property (p_reneg) else $error("renegotiation bit not set");

    c_remote: cover property (o_test_mode_flag);
    c_req: cover property (o_send_loop_request);
    c_full: cover property (i_rx_byte_valid ##2 (i_rd && i_addr == 8'h1E));
endmodule : mhr_checker

bind mhr_top mhr_checker #(.DW(DW)) chk_u (.*);

// file: tb/mhr_host.sv
// mhr_host.sv: host processor model on the register port
// assumes: sole master; tasks called from the bench
`timescale 1ns/1ps
module mhr_host
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // ----------------------------------------
    // bus cycles; a released bus shows inverted values
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
        @(posedge i_clk);
    endtask : rd
endmodule : mhr_host

// file: tb/modem_host_rx_ring_loopback_bits_bench.sv
// modem_host_rx_ring_loopback_bits_bench.sv: directed tests of mhr_top
// assumes: mhr_host drives the register port; bench drives the line side
`timescale 1ns/1ps
module modem_host_rx_ring_loopback_bits_bench
    import mhr_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr, i_wdata, o_rdata, i_rx_byte;
    logic [7:0] wakes = 8'h00;
    logic i_wr, i_rd, i_rx_byte_valid, i_rx_bit, o_rx_bit, i_data_mode, i_tone_mode, i_sleeping;
    logic o_wake, o_ring_indicator_output_n, i_rx_trained, i_rx_energy, i_rx_idle, i_rx_training;
    logic o_carrier_detect_pin_n, i_cts, i_dsr, o_cts_pin_n, o_dsr_pin_n, o_cts_status, o_dsr_status;
    logic o_send_loop_request, o_test_mode_flag, o_irq, ring_lvl;
    logic [4:0] pul;
    wire logic i_loop_established = pul[0];
    wire logic i_remote_loop_request = pul[1];
    wire logic i_remote_loop_end = pul[2];
    wire logic i_reneg_detect = pul[3];
    wire logic i_ring_detect_input = pul[4];
    wire logic i_ring_on = pul[4] | ring_lvl;
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] ra[6] = '{8'h1E, 8'h07, 8'h15, 8'h03, 8'h1A, 8'h21};
    logic [7:0] rm[6] = '{8'h45, 8'hC0, 8'h20, 8'h10, 8'h60, 8'h0F};
    logic [7:0] re[6] = '{8'h00, 8'h80, 8'h20, 8'h10, 8'h00, 8'h00};

    mhr_top dut_u (.*);
    mhr_host host_u (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd));

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_wake === 1'b1) wakes <= wakes + 8'h01;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd(a, v);
        chk(v & m, e);
    endtask : rdc
    task pulse(input int b);
        cyc(1);
        pul[b] <= 1'b1;
        cyc(1);
        pul[b] <= 1'b0;
    endtask : pulse
    task send(input logic [7:0] b);
        cyc(1);
        i_rx_byte <= b;
        i_rx_byte_valid <= 1'b1;
        cyc(1);
        i_rx_byte_valid <= 1'b0;
    endtask : send
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        {i_rx_byte_valid, i_rx_bit, i_data_mode, i_tone_mode, i_sleeping, i_rx_trained} = '0;
        {i_rx_energy, i_rx_training, ring_lvl, pul, i_rx_byte} = '0;
        {i_rx_idle, i_cts, i_dsr} = 3'b111;
        cyc(20);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 6; k++) rdc(ra[k], rm[k], re[k]);
        rdc(8'h55, 8'hFF, 8'h00);
        $display("reset values done");
        send(8'hA5);
        #1 chk(o_irq, 1'b0);
        rdc(8'h1E, 8'h41, 8'h01);
        rdc(8'h00, 8'hFF, 8'hA5);
        rdc(8'h1E, 8'h41, 8'h00);
        host_u.wr(8'h1E, 8'h04);
        send(8'h3C);
        #1 chk(o_irq, 1'b1);
        rdc(8'h1E, 8'h45, 8'h45);
        rdc(8'h00, 8'hFF, 8'h3C);
        #1 chk(o_irq, 1'b0);
        $display("receive buffer done");
        cyc(1);
        i_rx_idle <= 1'b0;
        i_rx_trained <= 1'b1;
        cyc(3);
        #1 chk({o_carrier_detect_pin_n, o_rx_bit}, 8'h00);
        rdc(8'h0F, 8'h80, 8'h80);
        host_u.wr(8'h03, 8'h00);
        #1 chk({o_carrier_detect_pin_n, o_rx_bit}, 8'h03);
        host_u.wr(8'h03, 8'h10);
        i_rx_training <= 1'b1;
        cyc(2);
        rdc(8'h0F, 8'h80, 8'h00);
        i_rx_training <= 1'b0;
        i_rx_trained <= 1'b0;
        i_rx_energy <= 1'b1;
        cyc(2);
        rdc(8'h0F, 8'h80, 8'h80);
        $display("carrier done");
        host_u.wr(8'h07, 8'hC0);
        cyc(2);
        #1 chk({o_send_loop_request, o_rx_bit, o_cts_pin_n, o_cts_status}, 8'h0E);
        pulse(0);
        #1 chk(o_send_loop_request, 1'b0);
        host_u.wr(8'h07, 8'h80);
        pulse(1);
        #1 chk({o_test_mode_flag, o_cts_pin_n, o_dsr_pin_n, o_carrier_detect_pin_n, o_rx_bit,
            o_cts_status, o_dsr_status}, 8'h7C);
        pulse(2);
        host_u.wr(8'h07, 8'h00);
        pulse(1);
        #1 chk(o_test_mode_flag, 1'b0);
        $display("loopback done");
        cyc(1);
        i_rx_idle <= 1'b1;
        ring_lvl <= 1'b1;
        cyc(3);
        #1 chk(o_ring_indicator_output_n, 1'b0);
        rdc(8'h0F, 8'h08, 8'h08);
        i_data_mode <= 1'b1;
        cyc(2);
        rdc(8'h0F, 8'h08, 8'h00);
        i_data_mode <= 1'b0;
        i_tone_mode <= 1'b1;
        cyc(2);
        rdc(8'h0F, 8'h08, 8'h00);
        i_tone_mode <= 1'b0;
        ring_lvl <= 1'b0;
        host_u.wr(8'h1A, 8'h60);
        #1 chk(o_ring_indicator_output_n, 1'b0);
        host_u.wr(8'h1A, 8'h40);
        #1 chk(o_ring_indicator_output_n, 1'b1);
        cyc(1);
        i_sleeping <= 1'b1;
        pulse(4);
        cyc(3);
        chk(wakes, 8'h01);
        host_u.wr(8'h15, 8'h00);
        pulse(4);
        cyc(3);
        chk(wakes, 8'h01);
        $display("ring done");
        rdc(8'h20, 8'h0F, 8'h0B);
        host_u.wr(8'h21, 8'h04);
        pulse(3);
        #1 chk(o_irq, 1'b1);
        rdc(8'h0E, 8'h20, 8'h20);
        rdc(8'h20, 8'h04, 8'h04);
        #1 chk(o_irq, 1'b0);
        host_u.wr(8'h0E, 8'h20);
        rdc(8'h0E, 8'h20, 8'h20);
        host_u.wr(8'h0E, 8'h00);
        rdc(8'h0E, 8'h20, 8'h00);
        $display("events done");
        tally_and_finish();
    end
endmodule : modem_host_rx_ring_loopback_bits_bench
